// *** core/core_regs.sv ***
// Core register file: accumulator, index pair, stack pointer, fetch counter,
// flag register, reset vector load, low-power modes and oscillator wait.
// Assumes memory answers a vector read with data one cycle after the request.
//
// The address-and-strobe port and the register addresses were left to the implementer.
`timescale 1ns/1ps
module core_regs #(
    parameter int OSC_CYCLES = core_regs_pkg::OSC_DELAY_CYCLES
) (
    input wire logic clk, // 50 MHz clock
    input wire logic sys_rst, // Synchronous reset, active high
    input wire logic clk_en, // Freezes all state while low
    input wire core_regs_pkg::op_req_t req, // Operation request
    input wire logic [7:0] mem_rdata, // Memory data, one cycle after mem_req
    input wire logic [7:0] irq_pending, // Maskable requests, bit 0 highest
    input wire logic ext_irq, // External interrupt, wakes stop
    input wire logic [3:0] reg_addr, // Register port address
    input wire logic [7:0] reg_wdata, // Register port write data
    input wire logic reg_wr, // Register port write strobe
    input wire logic reg_rd, // Register port read strobe
    output logic [7:0] reg_rdata, // Read data, cycle after reg_rd
    output core_regs_pkg::mem_req_t mem_req, // Vector read request
    output logic [15:0] operand_addr, // Stack-relative operand address
    output logic [2:0] irq_grant, // Serviced request number
    output logic irq_take, // Interrupt accepted pulse
    output logic illegal_op, // Illegal opcode pulse
    output logic core_clk_en, // Gated core clock enable
    output logic [7:0] push_data // Byte pushed on interrupt entry
);
    import core_regs_pkg::*;

    logic [7:0] accumulator;
    logic [15:0] index_pair;
    logic [15:0] stack_ptr;
    logic [15:0] fetch_counter;
    logic [7:0] flag_register;
    logic halt_permit_bit;
    logic config_locked;
    run_state_t state;
    logic [$clog2(OSC_CYCLES+1)-1:0] osc_cnt;
    logic [2:0] push_step;
    logic [7:0] alu_res;
    logic alu_c;
    logic alu_h;
    logic alu_v;
    logic upd_nz;
    logic upd_c;
    logic upd_hv;
    logic upd_v;
    logic [8:0] sum9;
    logic [4:0] sum5;
    logic [7:0] daa_adj;
    logic any_irq;
    logic [2:0] irq_num;
    logic running;
    logic [15:0] next_sp;
    logic vec_lo_due;

    assign running = (state == ST_RUN) && clk_en;

    always_comb begin
        irq_num = 3'd0;
        for (int i = 7; i >= 0; i--) begin
            if (irq_pending[i]) begin
                irq_num = 3'(i);
            end
        end
    end
    assign any_irq = (|irq_pending) && !flag_register[FLAG_I];

    // ALU: result and flag updates
    always_comb begin
        sum9 = 9'h000;
        sum5 = 5'h00;
        daa_adj = 8'h00;
        alu_res = accumulator;
        alu_c = flag_register[FLAG_C];
        alu_h = flag_register[FLAG_H];
        alu_v = flag_register[FLAG_V];
        upd_nz = 1'b1;
        upd_c = 1'b0;
        upd_hv = 1'b0;
        upd_v = 1'b0;
        case (req.op)
            OP_ADD, OP_ADC: begin
                sum9 = {1'b0, accumulator} + {1'b0, req.operand}
                    + {8'h00, (req.op == OP_ADC) & flag_register[FLAG_C]};
                sum5 = {1'b0, accumulator[3:0]} + {1'b0, req.operand[3:0]}
                    + {4'h0, (req.op == OP_ADC) & flag_register[FLAG_C]};
                alu_res = sum9[7:0];
                alu_c = sum9[8];
                alu_h = sum5[4];
                alu_v = (accumulator[7] == req.operand[7]) && (sum9[7] != accumulator[7]);
                upd_c = 1'b1;
                upd_hv = 1'b1;
            end
            OP_SUB: begin
                sum9 = {1'b0, accumulator} - {1'b0, req.operand};
                alu_res = sum9[7:0];
                alu_c = sum9[8];
                alu_v = (accumulator[7] != req.operand[7]) && (sum9[7] != accumulator[7]);
                upd_c = 1'b1;
                upd_v = 1'b1;
            end
            OP_AND: alu_res = accumulator & req.operand;
            OP_OR: alu_res = accumulator | req.operand;
            OP_EOR: alu_res = accumulator ^ req.operand;
            OP_LDA: alu_res = req.operand;
            OP_ASL, OP_ROL: begin
                alu_res = {accumulator[6:0], (req.op == OP_ROL) & flag_register[FLAG_C]};
                alu_c = accumulator[7];
                alu_v = accumulator[7] ^ accumulator[6];
                upd_c = 1'b1;
                upd_v = 1'b1;
            end
            OP_LSR, OP_ROR: begin
                alu_res = {(req.op == OP_ROR) & flag_register[FLAG_C], accumulator[7:1]};
                alu_c = accumulator[0];
                alu_v = alu_res[7] ^ accumulator[0];
                upd_c = 1'b1;
                upd_v = 1'b1;
            end
            // decimal adjust uses H and C
            OP_DAA: begin
                if (flag_register[FLAG_H] || accumulator[3:0] > 4'h9) begin
                    daa_adj[3:0] = 4'h6;
                end
                if (flag_register[FLAG_C] || accumulator > 8'h99) begin
                    daa_adj[7:4] = 4'h6;
                    alu_c = 1'b1;
                end
                alu_res = accumulator + daa_adj;
                upd_c = 1'b1;
            end
            OP_BTST: begin
                alu_c = req.operand[req.target[2:0]];
                upd_c = 1'b1;
                upd_nz = 1'b0;
            end
            default: upd_nz = 1'b0;
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            accumulator <= 8'h00;
        end else if (clk_en) begin
            if (reg_wr && reg_addr == ADDR_ACC) begin
                accumulator <= reg_wdata;
            end else if (running && upd_nz && req.op != OP_BTST) begin
                accumulator <= alu_res;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            index_pair <= 16'h0000;
        end else if (clk_en) begin
            if (reg_wr && reg_addr == ADDR_IDX_HI) begin
                index_pair[15:8] <= reg_wdata;
            end else if (reg_wr && reg_addr == ADDR_IDX_LO) begin
                index_pair[7:0] <= reg_wdata;
            end else if (running && req.op == OP_LDX) begin
                index_pair <= req.target;
            end
        end
    end

    // Stack pointer next value
    always_comb begin
        next_sp = stack_ptr;
        case (req.op)
            OP_PUSH: next_sp = stack_ptr - 16'h0001;
            OP_PULL: next_sp = stack_ptr + 16'h0001;
            OP_RTI: next_sp = stack_ptr + 16'h0005;
            OP_RSP: next_sp = {stack_ptr[15:8], SP_LOW_RESET};
            default: next_sp = stack_ptr;
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            stack_ptr <= SP_RESET;
        end else if (clk_en) begin
            if (reg_wr && reg_addr == ADDR_SP_HI) begin
                stack_ptr[15:8] <= reg_wdata;
            end else if (reg_wr && reg_addr == ADDR_SP_LO) begin
                stack_ptr[7:0] <= reg_wdata;
            end else if (push_step != 3'd0) begin
                stack_ptr <= stack_ptr - 16'h0001;
            end else if (state == ST_RUN) begin
                stack_ptr <= next_sp;
            end
        end
    end

    assign operand_addr = stack_ptr + (req.long_offset ? req.target : {8'h00, req.operand});

    // push five bytes; the fifth step also sets the mask and reads the vector
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            push_step <= 3'd0;
            irq_take <= 1'b0;
            irq_grant <= 3'd0;
        end else if (clk_en) begin
            irq_take <= 1'b0;
            if (push_step != 3'd0) begin
                push_step <= push_step - 3'd1;
            end else if ((state == ST_RUN || state == ST_WAIT) && any_irq) begin
                push_step <= 3'd5;
                irq_take <= 1'b1;
                irq_grant <= irq_num;
            end
        end
    end

    // Bytes stacked on entry; upper index byte is not among them
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            push_data <= 8'h00;
        end else if (clk_en) begin
            case (push_step)
                3'd5: push_data <= fetch_counter[7:0];
                3'd4: push_data <= fetch_counter[15:8];
                3'd3: push_data <= index_pair[7:0];
                3'd2: push_data <= accumulator;
                3'd1: push_data <= flag_register | FLAGS_ONES;
                default: push_data <= 8'h00;
            endcase
        end
    end

    // Run state and low-power modes
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state <= ST_VEC_HI;
            osc_cnt <= '0;
            illegal_op <= 1'b0;
        end else if (clk_en) begin
            illegal_op <= 1'b0;
            case (state)
                ST_VEC_HI: state <= ST_VEC_LO;
                ST_VEC_LO: state <= ST_RUN;
                ST_RUN: begin
                    if (req.op == OP_WAIT && push_step == 3'd0 && !any_irq) begin
                        state <= ST_WAIT;
                    end else if (req.op == OP_STOP && push_step == 3'd0) begin
                        if (halt_permit_bit) begin
                            state <= ST_STOP;
                        end else begin
                            illegal_op <= 1'b1;
                        end
                    end
                end
                ST_WAIT: if (any_irq) state <= ST_RUN;
                ST_STOP: begin
                    if (ext_irq) begin
                        state <= ST_OSC;
                        osc_cnt <= ($clog2(OSC_CYCLES+1))'(OSC_CYCLES);
                    end
                end
                ST_OSC: begin
                    if (osc_cnt <= 1) begin
                        state <= ST_RUN;
                    end
                    osc_cnt <= osc_cnt - 1'b1;
                end
                default: state <= ST_VEC_HI;
            endcase
        end
    end

    assign core_clk_en = clk_en && (state != ST_WAIT) && (state != ST_STOP)
        && (state != ST_OSC);

    always_comb begin
        mem_req.rd = (state == ST_VEC_HI) || (state == ST_VEC_LO) || (push_step == 3'd1);
        mem_req.addr = (state == ST_VEC_LO) ? VEC_LO_ADDR : VEC_HI_ADDR;
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            fetch_counter <= 16'h0000;
        end else if (clk_en) begin
            if (state == ST_VEC_LO) begin
                fetch_counter[15:8] <= mem_rdata;
            end else if (vec_lo_due) begin
                fetch_counter[7:0] <= mem_rdata;
            end else if (reg_wr && reg_addr == ADDR_PC_HI) begin
                fetch_counter[15:8] <= reg_wdata;
            end else if (reg_wr && reg_addr == ADDR_PC_LO) begin
                fetch_counter[7:0] <= reg_wdata;
            end else if (running && (req.op == OP_JUMP || req.op == OP_RTI)) begin
                fetch_counter <= req.target;
            end else if (running && push_step == 3'd0 && req.op == OP_FETCH) begin
                fetch_counter <= fetch_counter + 16'h0001;
            end
        end
    end

    // Vector low byte lands one cycle after the low read
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            vec_lo_due <= 1'b0;
        end else if (clk_en) begin
            vec_lo_due <= (state == ST_VEC_LO);
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            flag_register <= FLAGS_RESET;
        end else if (clk_en) begin
            if (reg_wr && reg_addr == ADDR_FLAGS) begin
                flag_register <= reg_wdata | FLAGS_ONES;
            end else if (push_step == 3'd1) begin
                flag_register[FLAG_I] <= 1'b1;
            end else if (running && push_step == 3'd0) begin
                case (req.op)
                    OP_CLI: flag_register[FLAG_I] <= 1'b0;
                    OP_SEI: flag_register[FLAG_I] <= 1'b1;
                    OP_RTI: flag_register <= req.operand | FLAGS_ONES;
                    OP_WAIT: flag_register[FLAG_I] <= 1'b0;
                    OP_STOP: if (halt_permit_bit) flag_register[FLAG_I] <= 1'b0;
                    default: begin
                        if (upd_nz) begin
                            flag_register[FLAG_N] <= alu_res[7];
                            flag_register[FLAG_Z] <= (alu_res == 8'h00);
                        end
                        if (upd_c) flag_register[FLAG_C] <= alu_c;
                        if (upd_hv) flag_register[FLAG_H] <= alu_h;
                        if (upd_hv || upd_v) flag_register[FLAG_V] <= alu_v;
                    end
                endcase
            end
            // entry mask wins over a same-cycle flag write
            if (push_step == 3'd1) begin
                flag_register[FLAG_I] <= 1'b1;
            end
        end
    end

    // Stop permit, write-once until reset
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            halt_permit_bit <= 1'b0;
            config_locked <= 1'b0;
        end else if (clk_en && reg_wr && reg_addr == ADDR_CONFIG && !config_locked) begin
            halt_permit_bit <= reg_wdata[0];
            config_locked <= 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            reg_rdata <= 8'h00;
        end else if (clk_en) begin
            reg_rdata <= 8'h00;
            if (reg_rd) begin
                case (reg_addr)
                    ADDR_ACC: reg_rdata <= accumulator;
                    ADDR_IDX_HI: reg_rdata <= index_pair[15:8];
                    ADDR_IDX_LO: reg_rdata <= index_pair[7:0];
                    ADDR_SP_HI: reg_rdata <= stack_ptr[15:8];
                    ADDR_SP_LO: reg_rdata <= stack_ptr[7:0];
                    ADDR_PC_HI: reg_rdata <= fetch_counter[15:8];
                    ADDR_PC_LO: reg_rdata <= fetch_counter[7:0];
                    ADDR_FLAGS: reg_rdata <= flag_register | FLAGS_ONES;
                    ADDR_STATUS: reg_rdata <= {5'h00, state};
                    ADDR_CONFIG: reg_rdata <= {6'h00, config_locked, halt_permit_bit};
                    default: reg_rdata <= 8'h00;
                endcase
            end
        end
    end

    AST_SP_RESET: assert property (@(posedge clk) $fell(sys_rst) |-> stack_ptr == SP_RESET)
        else $error("stack pointer not 00FF after reset");
    AST_RSP: assert property (@(posedge clk) disable iff (sys_rst)
        clk_en && state == ST_RUN && push_step == 0 && !reg_wr && req.op == OP_RSP
        |=> stack_ptr == {$past(stack_ptr[15:8]), 8'hFF})
        else $error("stack reset wrong");
    AST_PUSH: assert property (@(posedge clk) disable iff (sys_rst)
        clk_en && state == ST_RUN && push_step == 0 && !reg_wr && req.op == OP_PUSH
        |=> stack_ptr == $past(stack_ptr) - 16'h0001)
        else $error("push did not decrement");
    AST_ONES: assert property (@(posedge clk) disable iff (sys_rst)
        flag_register[6:5] == 2'b11)
        else $error("flag bits 6:5 not one");
    AST_MASK_RESET: assert property (@(posedge clk)
        $fell(sys_rst) |-> flag_register[FLAG_I])
        else $error("mask clear after reset");
    sequence s_entry;
        clk_en && irq_take;
    endsequence
    AST_ENTRY: assert property (@(posedge clk) disable iff (sys_rst)
        s_entry ##0 (clk_en && !reg_wr) [*5] |=> flag_register[FLAG_I])
        else $error("mask not set after entry");
    AST_ZERO: assert property (@(posedge clk) disable iff (sys_rst)
        running && push_step == 0 && !reg_wr && req.op == OP_LDA
        |=> flag_register[FLAG_Z] == ($past(req.operand) == 8'h00))
        else $error("zero flag wrong");
    AST_ILLEGAL: assert property (@(posedge clk) disable iff (sys_rst)
        running && push_step == 0 && req.op == OP_STOP && !halt_permit_bit
        |=> illegal_op && state == ST_RUN)
        else $error("stop not illegal");
    AST_OSC: assert property (@(posedge clk) disable iff (sys_rst)
        state == ST_STOP && clk_en && ext_irq |=> !core_clk_en)
        else $error("clock ran before delay");
endmodule : core_regs

// *** core/core_regs_pkg.sv ***
// Package for the core register file: register map, reset values, operation codes.
// Assumes a single 50 MHz clock domain and a synchronous active-high reset.
package core_regs_pkg;
    // Software port register indices (byte addresses = index)
    localparam logic [3:0] ADDR_ACC = 4'h0;
    localparam logic [3:0] ADDR_IDX_HI = 4'h1;
    localparam logic [3:0] ADDR_IDX_LO = 4'h2;
    localparam logic [3:0] ADDR_SP_HI = 4'h3;
    localparam logic [3:0] ADDR_SP_LO = 4'h4;
    localparam logic [3:0] ADDR_PC_HI = 4'h5;
    localparam logic [3:0] ADDR_PC_LO = 4'h6;
    localparam logic [3:0] ADDR_FLAGS = 4'h7;
    localparam logic [3:0] ADDR_STATUS = 4'h8;
    localparam logic [3:0] ADDR_CONFIG = 4'h9;
    // Reset values
    localparam logic [15:0] SP_RESET = 16'h00FF;
    localparam logic [7:0] SP_LOW_RESET = 8'hFF;
    localparam logic [15:0] VEC_HI_ADDR = 16'hFFFE;
    localparam logic [15:0] VEC_LO_ADDR = 16'hFFFF;
    localparam logic [7:0] FLAGS_RESET = 8'h68; // I set, bits 6:5 ones
    localparam logic [7:0] FLAGS_ONES = 8'h60;
    // Flag bit positions
    localparam int FLAG_C = 0;
    localparam int FLAG_Z = 1;
    localparam int FLAG_N = 2;
    localparam int FLAG_I = 3;
    localparam int FLAG_H = 4;
    localparam int FLAG_V = 7;
    // Oscillator stabilisation delay
    localparam int OSC_DELAY_NS = 82000;
    localparam int CLK_PERIOD_NS = 20;
    localparam int OSC_DELAY_CYCLES = (OSC_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Operation codes
    typedef enum logic [4:0] {
        OP_NONE = 5'h00, OP_ADD = 5'h01, OP_ADC = 5'h02, OP_SUB = 5'h03,
        OP_AND = 5'h04, OP_OR = 5'h05, OP_EOR = 5'h06, OP_LDA = 5'h07,
        OP_ASL = 5'h08, OP_LSR = 5'h09, OP_ROL = 5'h0A, OP_ROR = 5'h0B,
        OP_PUSH = 5'h0C, OP_PULL = 5'h0D, OP_RSP = 5'h0E, OP_FETCH = 5'h0F,
        OP_JUMP = 5'h10, OP_IRQ = 5'h11, OP_RTI = 5'h12, OP_CLI = 5'h13,
        OP_SEI = 5'h14, OP_WAIT = 5'h15, OP_STOP = 5'h16, OP_DAA = 5'h17,
        OP_BTST = 5'h18, OP_LDX = 5'h19, OP_SPADDR = 5'h1A
    } op_t;
    typedef enum logic [2:0] {
        ST_VEC_HI = 3'b000, ST_VEC_LO = 3'b001, ST_RUN = 3'b011,
        ST_WAIT = 3'b010, ST_STOP = 3'b110, ST_OSC = 3'b111
    } run_state_t;
    // Operation request bundle
    typedef struct packed {
        op_t op;
        logic [7:0] operand;
        logic [15:0] target;
        logic long_offset;
    } op_req_t;
    // Memory read request bundle
    typedef struct packed {
        logic rd;
        logic [15:0] addr;
    } mem_req_t;
endpackage : core_regs_pkg

// *** tb/cpu_register_file_flags_tb.sv ***
// Testbench for the core register file: register port tasks plus operation requests.
// Assumes vec_mem as vector memory and a shortened oscillator wait of 4 cycles.
`timescale 1ns/1ps
module cpu_register_file_flags_tb;
    import core_regs_pkg::*;
    logic clk = 0, sys_rst = 1, ext_irq = 0, reg_wr = 0, reg_rd = 0, illegal_op, core_clk_en;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00, reg_rdata, mem_rdata;
    logic [15:0] operand_addr;
    op_req_t req = '0;
    mem_req_t mem_req;
    logic [7:0] irq_pending = 8'h00, push_data;
    logic [2:0] irq_grant;
    logic irq_take;
    int error_cnt = 0, compares = 0, cyc = 0;
    // Clock, 20 ns period
    always #10 clk = ~clk;
    core_regs #(.OSC_CYCLES(4)) DUT (.clk(clk), .sys_rst(sys_rst), .clk_en(1'b1), .req(req),
        .mem_rdata(mem_rdata), .irq_pending(irq_pending), .ext_irq(ext_irq),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .mem_req(mem_req), .operand_addr(operand_addr),
        .irq_grant(irq_grant), .irq_take(irq_take), .illegal_op(illegal_op),
        .core_clk_en(core_clk_en), .push_data(push_data));
    vec_mem MEM (.mem_req(mem_req), .clk(clk), .mem_rdata(mem_rdata));
    task end_of_test;
        $display("errors %0d compares %0d", error_cnt, compares);
        if (error_cnt == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : end_of_test
    task chk(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // Reset held 8 cycles, then room for the vector fetch
    task rst;
        sys_rst <= 1'b1;
        repeat (8) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (4) @(posedge clk);
    endtask : rst
    task wr(input logic [3:0] a, input logic [7:0] d);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr
    // Data sampled at the edge that closes the answer cycle, before it clears
    task rd(input logic [3:0] a, input logic [7:0] exp, input logic [7:0] m = 8'hFF);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(posedge clk);
        chk({8'h00, reg_rdata & m}, {8'h00, exp});
    endtask : rd
    task op(input op_t o, input logic [7:0] v, input logic [15:0] t = 16'h0000);
        req <= '{o, v, t, 1'b0};
        @(posedge clk);
        req <= '0;
    endtask : op
    // Hang guard, far above the roughly 135 cycles the sequence needs
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            error_cnt++;
            end_of_test;
        end
    end
    // Main sequence; overflow is masked off in the first flag read after reset
    initial begin
        rst;
        rd(ADDR_SP_HI, 8'h00);
        rd(ADDR_SP_LO, 8'hFF);
        rd(ADDR_FLAGS, 8'h68, 8'h7F);
        rd(ADDR_PC_HI, 8'h3C);
        rd(ADDR_PC_LO, 8'h5A);
        wr(ADDR_ACC, 8'h88);
        op(OP_ADD, 8'h88);
        rd(ADDR_ACC, 8'h10);
        rd(ADDR_FLAGS, 8'hF9);
        op(OP_SUB, 8'h11);
        rd(ADDR_FLAGS, 8'h7D);
        op(OP_AND, 8'h00);
        rd(ADDR_FLAGS, 8'h7B);
        wr(ADDR_SP_HI, 8'h12);
        op(OP_RSP, 8'h00);
        rd(ADDR_SP_HI, 8'h12);
        rd(ADDR_SP_LO, 8'hFF);
        op(OP_PUSH, 8'h00);
        rd(ADDR_SP_LO, 8'hFE);
        op(OP_PULL, 8'h00);
        rd(ADDR_SP_LO, 8'hFF);
        req <= '{OP_SPADDR, 8'h05, 16'h0000, 1'b0};
        @(posedge clk);
        chk(operand_addr, 16'h1304);
        op(OP_CLI, 8'h00);
        rd(ADDR_FLAGS, 8'h73);
        wr(ADDR_FLAGS, 8'h00);
        rd(ADDR_FLAGS, 8'h60);
        op(OP_STOP, 8'h00);
        @(posedge clk);
        chk({15'h0000, illegal_op}, 16'h0001);
        op(OP_SEI, 8'h00);
        @(posedge clk);
        op(OP_WAIT, 8'h00);
        @(posedge clk);
        chk({15'h0000, core_clk_en}, 16'h0000);
        rd(ADDR_FLAGS, 8'h00, 8'h08);
        rst;
        rd(ADDR_FLAGS, 8'h08, 8'h08);
        wr(ADDR_CONFIG, 8'h01);
        rd(ADDR_CONFIG, 8'h03);
        wr(ADDR_CONFIG, 8'h00);
        op(OP_STOP, 8'h00);
        @(posedge clk);
        chk({15'h0000, core_clk_en}, 16'h0000);
        ext_irq <= 1'b1;
        // Last halted cycle of the shortened oscillator wait, then running
        repeat (5) @(posedge clk);
        chk({15'h0000, core_clk_en}, 16'h0000);
        @(posedge clk);
        chk({15'h0000, core_clk_en}, 16'h0001);
        ext_irq <= 1'b0;
        rd(ADDR_FLAGS, 8'h00, 8'h08);
        // Interrupt entry; service code keeps the upper index byte itself
        wr(ADDR_IDX_HI, 8'hA5);
        irq_pending <= 8'h06;
        repeat (2) @(posedge clk);
        chk({15'h0000, irq_take}, 16'h0001);
        chk({13'h0000, irq_grant}, 16'h0001);
        @(posedge clk);
        chk({8'h00, push_data}, 16'h005A);
        repeat (4) @(posedge clk);
        rd(ADDR_FLAGS, 8'h08, 8'h08);
        chk({15'h0000, irq_take}, 16'h0000);
        irq_pending <= 8'h00;
        rd(ADDR_SP_LO, 8'hFA);
        rd(ADDR_IDX_HI, 8'hA5);
        op(OP_RTI, 8'h01, 16'h2000);
        rd(ADDR_FLAGS, 8'h61);
        rd(ADDR_SP_LO, 8'hFF);
        op(OP_FETCH, 8'h00);
        rd(ADDR_PC_LO, 8'h01);
        op(OP_JUMP, 8'h00, 16'h4321);
        rd(ADDR_PC_HI, 8'h43);
        op(OP_LDA, 8'h00);
        rd(ADDR_FLAGS, 8'h63);
        op(OP_ADC, 8'h09);
        rd(ADDR_ACC, 8'h0A);
        op(OP_DAA, 8'h00);
        rd(ADDR_ACC, 8'h10);
        op(OP_LDA, 8'h81);
        rd(ADDR_FLAGS, 8'h64);
        op(OP_ASL, 8'h00);
        rd(ADDR_FLAGS, 8'hE1);
        op(OP_BTST, 8'h04, 16'h0000);
        rd(ADDR_FLAGS, 8'hE0);
        op(OP_LDX, 8'h00, 16'hBEEF);
        rd(ADDR_IDX_LO, 8'hEF);
        end_of_test;
    end
endmodule : cpu_register_file_flags_tb

// *** tb/vec_mem.sv ***
// Partner memory for the core: answers vector reads one cycle after the request.
// Assumes one clock and the request bundle of core_regs_pkg.
`timescale 1ns/1ps
module vec_mem #(
    parameter logic [7:0] VEC_HI = 8'h3C, // Reset vector high byte, arbitrary
    parameter logic [7:0] VEC_LO = 8'h5A // Reset vector low byte, arbitrary
) (
    input wire core_regs_pkg::mem_req_t mem_req, // Vector read request
    input wire logic clk, // Core clock
    output logic [7:0] mem_rdata // Data one cycle after the request
);
    import core_regs_pkg::*;
    initial mem_rdata = 8'h00;
    // vector bytes
    // Idle data toggles, so a stale byte is never taken for an answer
    always @(posedge clk) begin
        if (mem_req.rd) begin
            mem_rdata <= (mem_req.addr == VEC_HI_ADDR) ? VEC_HI : VEC_LO;
        end else begin
            mem_rdata <= ~mem_rdata;
        end
    end
endmodule : vec_mem
